// ### dsa_pkg.sv
// constants and types for the dual-slope converter sequencer
package dsa_pkg;
    // phase lengths in converter clock periods (ticks), stored as last index
    localparam logic [12:0] INT_LAST    = 13'h07FF;  // 2048 ticks of signal integrate
    localparam logic [12:0] DE_LAST     = 13'h0FFF;  // 4096 ticks of de-integrate
    localparam logic [12:0] ZI_LAST     = 13'h03FF;  // 1024 ticks of zero integrator at most
    localparam logic [12:0] CYCLE_LAST  = 13'h1FFF;  // 8192 ticks per free-running cycle
    localparam logic [12:0] AZ_MIN_LAST = 13'h03FF;  // 1024 ticks of auto-zero at least
    localparam logic [2:0]  HOLD_LAST   = 3'h6;      // 7 ticks from run to integrate
    localparam logic [2:0]  SEND_SETTLE = 3'h5;      // clocks before a send answer is trusted
    localparam logic [12:0] CNT_ONE     = 13'h0001;
    localparam logic [11:0] FULL_SCALE  = 12'hFFF;

    // pin synchroniser bit positions and idle (pulled) levels
    localparam int unsigned PIN_N      = 7;
    localparam int unsigned PIN_CMP    = 0;
    localparam int unsigned PIN_MODE   = 1;
    localparam int unsigned PIN_RUN    = 2;
    localparam int unsigned PIN_SEND   = 3;
    localparam int unsigned PIN_CE     = 4;
    localparam int unsigned PIN_LBYTE  = 5;
    localparam int unsigned PIN_UBYTE  = 6;
    localparam logic [6:0]  PIN_RESET  = 7'h7C;  // mode low, others high, comparator low

    // register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_RESULT = 12'h004;
    localparam logic [11:0] ADDR_STATE  = 12'h008;
    localparam int unsigned CTRL_HOLD   = 0;
    localparam int unsigned CTRL_TRIG   = 1;
    localparam logic        CTRL_HOLD_RESET = 1'b0;
    localparam int unsigned RES_SIGN    = 12;
    localparam int unsigned RES_OVER    = 13;
    localparam int unsigned ST_STATUS   = 0;
    localparam int unsigned ST_IDLE     = 1;
    localparam int unsigned ST_PHASE    = 4;
    localparam int unsigned ST_HS       = 8;

    typedef enum logic [1:0] {
        PH_AZ  = 2'b00,
        PH_INT = 2'b01,
        PH_DE  = 2'b10,
        PH_ZI  = 2'b11
    } dsa_phase_t;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_WAIT_H = 3'b001,
        HS_LOAD_H = 3'b010,
        HS_HOLD_H = 3'b011,
        HS_LOAD_L = 3'b100,
        HS_HOLD_L = 3'b101
    } dsa_hs_t;
endpackage

// ### dsa_seq.sv
// dual-slope converter sequencer with result latch, byte port, handshake and apb
//
// Contract
// - auto-zero phase: inputs to common, offset loop closed, reference cap charged.
// - signal integrate lasts exactly 2048 converter clock periods.
// - comparator sampled at integrate end gives sign and reference polarity.
// - de-integrate counts periods until comparator crossing; count is magnitude.
// - zero integrator only after over-range, at most 1024 periods.
// - zero integrator: inputs off, reference recharged, comparator fed back.
// - 12-bit count latched with sign and over-range, three-state drivers.
// - status rises at integrate start, falls just after latch update.
// - output latches never change while status is low.
// - mode low or open selects direct mode; pull-down holds it low.
// - mode pulse starts handshake, two bytes sent, then direct mode again.
// - mode held high gives handshake transfer after every conversion.
// - run high or open converts continuously; pull-up holds it high.
// - run low after crossing abandons de-integrate, straight to auto-zero.
// - run low: finish conversion, minimum auto-zero, then idle in auto-zero.
// - run rising during idle: status and integrate start 7 periods later.
// - direct mode: active-low enables, byte drives only with both enables low.
// - low byte carries bits 1-8; high byte bits 9-12, sign, over-range.
// - handshake generates all strobes and flags to load both bytes.
// - free-running cycle is 8192 periods: auto-zero, integrate, de-integrate, zero.
// - handshake: after receiver-ready, load strobe low one period with byte.
// - mode ignored during handshake; latch updates blocked until it ends.
// - conversion ending during handshake has its result discarded.
module dsa_seq #(
    parameter int unsigned DIV = 4
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_comparator,
    input  wire logic        i_mode,
    input  wire logic        i_run_hold,
    input  wire logic        i_send,
    input  wire logic        i_chip_enable_n,
    output logic             o_chip_enable_n,
    output logic             o_chip_enable_oe_n,
    input  wire logic        i_lower_byte_select_n,
    output logic             o_lower_byte_select_n,
    output logic             o_lower_byte_select_oe_n,
    input  wire logic        i_upper_byte_select_n,
    output logic             o_upper_byte_select_n,
    output logic             o_upper_byte_select_oe_n,
    output logic [7:0]       o_data_low,
    output logic             o_data_low_oe_n,
    output logic [5:0]       o_data_high,
    output logic             o_data_high_oe_n,
    output logic             o_status,
    output logic             o_auto_zero_phase,
    output logic             o_integrate_phase,
    output logic             o_reference_deintegrate_phase,
    output logic             o_zero_integrator_phase,
    output logic             o_sign_bit,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr
);
    localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

    // pin synchronisers: three stages, change accepted when stages two and three agree
    logic [6:0] pin_raw;
    logic [6:0] s1_q;
    logic [6:0] s2_q;
    logic [6:0] s3_q;
    logic [6:0] pin_q;
    logic [6:0] pin_d;
    assign pin_raw = {i_upper_byte_select_n, i_lower_byte_select_n, i_chip_enable_n,
                      i_send, i_run_hold, i_mode, i_comparator};
    genvar gi;
    generate
        for (gi = 0; gi < dsa_pkg::PIN_N; gi = gi + 1) begin : g_sync
            always_comb begin
                pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
            end
            always_ff @(posedge i_clk_sys) begin
                if (!i_resetn) begin
                    s1_q[gi]  <= dsa_pkg::PIN_RESET[gi];
                    s2_q[gi]  <= dsa_pkg::PIN_RESET[gi];
                    s3_q[gi]  <= dsa_pkg::PIN_RESET[gi];
                    pin_q[gi] <= dsa_pkg::PIN_RESET[gi];
                end else begin
                    s1_q[gi]  <= pin_raw[gi];
                    s2_q[gi]  <= s1_q[gi];
                    s3_q[gi]  <= s2_q[gi];
                    pin_q[gi] <= pin_d[gi];
                end
            end
        end
    endgenerate

    logic cmp_s;
    logic mode_s;
    logic run_s;
    logic send_s;
    logic ce_n_s;
    logic lbyte_n_s;
    logic ubyte_n_s;
    assign cmp_s     = pin_q[dsa_pkg::PIN_CMP];
    assign mode_s    = pin_q[dsa_pkg::PIN_MODE];
    assign run_s     = pin_q[dsa_pkg::PIN_RUN];
    assign send_s    = pin_q[dsa_pkg::PIN_SEND];
    assign ce_n_s    = pin_q[dsa_pkg::PIN_CE];
    assign lbyte_n_s = pin_q[dsa_pkg::PIN_LBYTE];
    assign ubyte_n_s = pin_q[dsa_pkg::PIN_UBYTE];

    // converter clock: one-cycle tick every DIV system clocks
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic        tick;
    always_comb begin
        tick  = (div_q == DIV_LAST);
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) div_q <= 16'h0000;
        else           div_q <= div_d;
    end

    // control register and handshake state shared with the phase logic
    logic              ctrl_hold_q;
    logic              hold_req;
    dsa_pkg::dsa_hs_t  hs_q;
    dsa_pkg::dsa_hs_t  hs_d;
    logic              hs_busy;
    assign hold_req = !run_s || ctrl_hold_q;
    assign hs_busy  = (hs_q != dsa_pkg::HS_IDLE);

    // phase sequencer and de-integrate counter
    dsa_pkg::dsa_phase_t phase_q;
    dsa_pkg::dsa_phase_t phase_d;
    logic [12:0] ph_cnt_q;
    logic [12:0] ph_cnt_d;
    logic [12:0] cyc_q;
    logic [12:0] cyc_d;
    logic        sign_q;
    logic        sign_d;
    logic        crossed_q;
    logic        crossed_d;
    logic        idle_q;
    logic        idle_d;
    logic [2:0]  start_q;
    logic [2:0]  start_d;
    logic        latch_evt;
    logic        over_evt;
    logic        enter_int;
    always_comb begin
        phase_d   = phase_q;
        ph_cnt_d  = ph_cnt_q;
        cyc_d     = cyc_q;
        sign_d    = sign_q;
        crossed_d = crossed_q;
        idle_d    = idle_q;
        start_d   = start_q;
        latch_evt = 1'b0;
        over_evt  = 1'b0;
        enter_int = 1'b0;
        if (tick) begin
            cyc_d    = cyc_q + dsa_pkg::CNT_ONE;
            ph_cnt_d = ph_cnt_q + dsa_pkg::CNT_ONE;
            case (phase_q)
                dsa_pkg::PH_AZ: begin
                    // saturate so a long hold cannot wrap the minimum auto-zero count
                    if (ph_cnt_q >= dsa_pkg::AZ_MIN_LAST) ph_cnt_d = ph_cnt_q;
                    if (hold_req) begin
                        idle_d  = 1'b1;
                        start_d = 3'h0;
                    end else if (idle_q) begin
                        if (ph_cnt_q >= dsa_pkg::AZ_MIN_LAST) begin
                            if (start_q == dsa_pkg::HOLD_LAST) enter_int = 1'b1;
                            else start_d = start_q + 3'h1;
                        end
                    end else if (cyc_q == dsa_pkg::CYCLE_LAST) begin
                        enter_int = 1'b1;
                    end
                    if (enter_int) begin
                        phase_d  = dsa_pkg::PH_INT;
                        ph_cnt_d = 13'h0000;
                        cyc_d    = 13'h0000;
                        idle_d   = 1'b0;
                        start_d  = 3'h0;
                    end
                end
                dsa_pkg::PH_INT: begin
                    if (ph_cnt_q == dsa_pkg::INT_LAST) begin
                        sign_d    = cmp_s;
                        phase_d   = dsa_pkg::PH_DE;
                        ph_cnt_d  = 13'h0000;
                        crossed_d = 1'b0;
                    end
                end
                dsa_pkg::PH_DE: begin
                    if (!crossed_q && (cmp_s != sign_q)) begin
                        crossed_d = 1'b1;
                        latch_evt = 1'b1;
                    end
                    if (ph_cnt_q == dsa_pkg::DE_LAST) begin
                        ph_cnt_d = 13'h0000;
                        if (!crossed_d) begin
                            over_evt  = 1'b1;
                            latch_evt = 1'b1;
                            phase_d   = dsa_pkg::PH_ZI;
                        end else begin
                            phase_d = dsa_pkg::PH_AZ;
                        end
                    end else if (crossed_d && hold_req) begin
                        phase_d  = dsa_pkg::PH_AZ;
                        ph_cnt_d = 13'h0000;
                        idle_d   = 1'b1;
                        start_d  = 3'h0;
                    end
                end
                dsa_pkg::PH_ZI: begin
                    if (ph_cnt_q == dsa_pkg::ZI_LAST) begin
                        phase_d  = dsa_pkg::PH_AZ;
                        ph_cnt_d = 13'h0000;
                    end
                end
                default: phase_d = dsa_pkg::PH_AZ;
            endcase
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            phase_q   <= dsa_pkg::PH_AZ;
            ph_cnt_q  <= 13'h0000;
            cyc_q     <= 13'h0000;
            sign_q    <= 1'b0;
            crossed_q <= 1'b0;
            idle_q    <= 1'b0;
            start_q   <= 3'h0;
        end else begin
            phase_q   <= phase_d;
            ph_cnt_q  <= ph_cnt_d;
            cyc_q     <= cyc_d;
            sign_q    <= sign_d;
            crossed_q <= crossed_d;
            idle_q    <= idle_d;
            start_q   <= start_d;
        end
    end

    // analog switch controls decoded from the phase register
    assign o_auto_zero_phase             = (phase_q == dsa_pkg::PH_AZ);
    assign o_integrate_phase             = (phase_q == dsa_pkg::PH_INT);
    assign o_reference_deintegrate_phase = (phase_q == dsa_pkg::PH_DE);
    assign o_zero_integrator_phase       = (phase_q == dsa_pkg::PH_ZI);
    assign o_sign_bit                    = sign_q;

    // result latches and status flag
    logic [11:0] res_q;
    logic [11:0] res_d;
    logic        res_sign_q;
    logic        res_sign_d;
    logic        res_over_q;
    logic        res_over_d;
    logic        stat_q;
    logic        stat_d;
    logic        drop_q;
    logic        drop_d;
    logic        stored;
    always_comb begin
        res_d      = res_q;
        res_sign_d = res_sign_q;
        res_over_d = res_over_q;
        stat_d     = stat_q;
        drop_d     = drop_q;
        stored     = latch_evt && !hs_busy;
        if (stored) begin
            res_d      = over_evt ? dsa_pkg::FULL_SCALE : ph_cnt_q[11:0];
            res_sign_d = sign_q;
            res_over_d = over_evt;
        end
        if (latch_evt) begin
            drop_d = 1'b1;
        end else if (drop_q && tick) begin
            stat_d = 1'b0;
            drop_d = 1'b0;
        end
        if (enter_int) stat_d = 1'b1;
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            res_q      <= 12'h000;
            res_sign_q <= 1'b0;
            res_over_q <= 1'b0;
            stat_q     <= 1'b0;
            drop_q     <= 1'b0;
        end else begin
            res_q      <= res_d;
            res_sign_q <= res_sign_d;
            res_over_q <= res_over_d;
            stat_q     <= stat_d;
            drop_q     <= drop_d;
        end
    end
    assign o_status = stat_q;

    // handshake sequencer: request flag and byte transfer states
    logic mode_prev_q;
    logic pend_q;
    logic pend_d;
    logic sw_trig;
    logic [2:0] guard_q;
    logic [2:0] guard_d;
    always_comb begin
        pend_d = pend_q;
        hs_d   = hs_q;
        // hold states let a busy answer cross the synchroniser before trusting send
        guard_d = 3'h0;
        if ((hs_q == dsa_pkg::HS_HOLD_H) || (hs_q == dsa_pkg::HS_HOLD_L)) begin
            guard_d = (guard_q == dsa_pkg::SEND_SETTLE) ? guard_q : guard_q + 3'h1;
        end
        if (!hs_busy && ((mode_s && !mode_prev_q) || sw_trig)) pend_d = 1'b1;
        if (stored && mode_s) pend_d = 1'b1;
        if (tick) begin
            case (hs_q)
                dsa_pkg::HS_IDLE:   if (pend_q && !latch_evt) begin
                    hs_d   = dsa_pkg::HS_WAIT_H;
                    pend_d = 1'b0;
                end
                dsa_pkg::HS_WAIT_H: if (send_s) hs_d = dsa_pkg::HS_LOAD_H;
                dsa_pkg::HS_LOAD_H: hs_d = dsa_pkg::HS_HOLD_H;
                dsa_pkg::HS_HOLD_H: if (send_s && (guard_q == dsa_pkg::SEND_SETTLE)) begin
                    hs_d = dsa_pkg::HS_LOAD_L;
                end
                dsa_pkg::HS_LOAD_L: hs_d = dsa_pkg::HS_HOLD_L;
                dsa_pkg::HS_HOLD_L: if (send_s && (guard_q == dsa_pkg::SEND_SETTLE)) begin
                    hs_d = dsa_pkg::HS_IDLE;
                end
                default:            hs_d = dsa_pkg::HS_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            hs_q        <= dsa_pkg::HS_IDLE;
            pend_q      <= 1'b0;
            mode_prev_q <= 1'b0;
            guard_q     <= 3'h0;
        end else begin
            hs_q        <= hs_d;
            pend_q      <= pend_d;
            mode_prev_q <= mode_s;
            guard_q     <= guard_d;
        end
    end

    // control pins and byte drivers
    logic hs_upper;
    logic hs_lower;
    logic ctl_drive;
    always_comb begin
        hs_upper  = (hs_q == dsa_pkg::HS_LOAD_H) || (hs_q == dsa_pkg::HS_HOLD_H);
        hs_lower  = (hs_q == dsa_pkg::HS_LOAD_L) || (hs_q == dsa_pkg::HS_HOLD_L);
        ctl_drive = mode_s || hs_busy;
        o_chip_enable_n          = !((hs_q == dsa_pkg::HS_LOAD_H) ||
                                     (hs_q == dsa_pkg::HS_LOAD_L));
        o_upper_byte_select_n    = !hs_upper;
        o_lower_byte_select_n    = !hs_lower;
        o_chip_enable_oe_n       = !ctl_drive;
        o_upper_byte_select_oe_n = !ctl_drive;
        o_lower_byte_select_oe_n = !ctl_drive;
        if (hs_busy) begin
            o_data_high_oe_n = !hs_upper;
            o_data_low_oe_n  = !hs_lower;
        end else if (!mode_s) begin
            o_data_high_oe_n = !(!ce_n_s && !ubyte_n_s);
            o_data_low_oe_n  = !(!ce_n_s && !lbyte_n_s);
        end else begin
            o_data_high_oe_n = 1'b1;
            o_data_low_oe_n  = 1'b1;
        end
    end
    assign o_data_low  = res_q[7:0];
    assign o_data_high = {res_over_q, res_sign_q, res_q[11:8]};

    // apb slave: zero-wait access, read data captured in the setup cycle
    logic        apb_setup;
    logic        apb_access;
    logic        addr_ok;
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;
    logic        ctrl_hold_d;
    always_comb begin
        apb_setup   = i_psel && !i_penable;
        apb_access  = i_psel && i_penable;
        addr_ok     = (i_paddr == dsa_pkg::ADDR_CTRL) || (i_paddr == dsa_pkg::ADDR_RESULT) ||
                      (i_paddr == dsa_pkg::ADDR_STATE);
        ctrl_hold_d = ctrl_hold_q;
        sw_trig     = 1'b0;
        prdata_d    = prdata_q;
        if (apb_access && i_pwrite && (i_paddr == dsa_pkg::ADDR_CTRL)) begin
            ctrl_hold_d = i_pwdata[dsa_pkg::CTRL_HOLD];
            sw_trig     = i_pwdata[dsa_pkg::CTRL_TRIG];
        end
        if (apb_setup) begin
            prdata_d = 32'h0000_0000;
            if (i_paddr == dsa_pkg::ADDR_CTRL) begin
                prdata_d[dsa_pkg::CTRL_HOLD] = ctrl_hold_q;
            end else if (i_paddr == dsa_pkg::ADDR_RESULT) begin
                prdata_d[11:0]              = res_q;
                prdata_d[dsa_pkg::RES_SIGN] = res_sign_q;
                prdata_d[dsa_pkg::RES_OVER] = res_over_q;
            end else if (i_paddr == dsa_pkg::ADDR_STATE) begin
                prdata_d[dsa_pkg::ST_STATUS]        = stat_q;
                prdata_d[dsa_pkg::ST_IDLE]          = idle_q;
                prdata_d[dsa_pkg::ST_PHASE +: 2]    = phase_q;
                prdata_d[dsa_pkg::ST_HS +: 3]       = hs_q;
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ctrl_hold_q <= dsa_pkg::CTRL_HOLD_RESET;
            prdata_q    <= 32'h0000_0000;
        end else begin
            ctrl_hold_q <= ctrl_hold_d;
            prdata_q    <= prdata_d;
        end
    end
    assign o_prdata  = prdata_q;
    assign o_pready  = apb_access;
    assign o_pslverr = apb_access && !addr_ok;

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    chk_int_end_move: assert property ((phase_q == dsa_pkg::PH_INT) && tick &&
        (ph_cnt_q == dsa_pkg::INT_LAST) |=> (phase_q == dsa_pkg::PH_DE) && (ph_cnt_q == 13'h0000))
        else $error("integrate did not end after 2048 ticks");
    chk_int_early_stay: assert property ((phase_q == dsa_pkg::PH_INT) &&
        (ph_cnt_q != dsa_pkg::INT_LAST) |=> (phase_q == dsa_pkg::PH_INT))
        else $error("integrate left early");
    chk_zi_bound_len: assert property ((phase_q == dsa_pkg::PH_ZI) |->
        (ph_cnt_q <= dsa_pkg::ZI_LAST))
        else $error("zero integrator overran 1024 ticks");
    chk_zi_entry_over: assert property ((phase_q == dsa_pkg::PH_ZI) &&
        ($past(phase_q) != dsa_pkg::PH_ZI) |-> !$past(crossed_q) && $past(over_evt))
        else $error("zero integrator without over-range");
    chk_latch_status_high: assert property (((res_q != $past(res_q)) ||
        (res_over_q != $past(res_over_q))) |-> $past(stat_q))
        else $error("latch changed while status low");
    chk_status_drop_time: assert property (latch_evt |=> stat_q && drop_q)
        else $error("status dropped too early");
    chk_status_drop_fall: assert property (drop_q && tick && !latch_evt |=> !stat_q)
        else $error("status did not drop one tick after latch");
    chk_discard_busy: assert property (latch_evt && hs_busy |=> $stable(res_q))
        else $error("result latched during handshake");
    chk_load_one_tick: assert property ((hs_q == dsa_pkg::HS_LOAD_H) && tick |=>
        (hs_q == dsa_pkg::HS_HOLD_H) && o_chip_enable_n && !o_upper_byte_select_n)
        else $error("load strobe longer than one period");
    chk_hold_start_int: assert property ((phase_q == dsa_pkg::PH_AZ) && idle_q && tick &&
        !hold_req && (ph_cnt_q >= dsa_pkg::AZ_MIN_LAST) && (start_q == dsa_pkg::HOLD_LAST)
        |=> (phase_q == dsa_pkg::PH_INT) && stat_q)
        else $error("integrate did not start 7 ticks after run");
    chk_abandon_deint: assert property ((phase_q == dsa_pkg::PH_DE) && crossed_q &&
        hold_req && tick && (ph_cnt_q != dsa_pkg::DE_LAST) |=> (phase_q == dsa_pkg::PH_AZ))
        else $error("de-integrate not abandoned on hold");
    chk_bytes_exclusive: assert property (hs_busy |->
        !(!o_data_low_oe_n && !o_data_high_oe_n))
        else $error("both bytes driven in handshake");

    cov_overrange: cover property ((phase_q == dsa_pkg::PH_DE) ##1 (phase_q == dsa_pkg::PH_ZI));
    cov_hs_done: cover property ((hs_q == dsa_pkg::HS_HOLD_L) ##1 (hs_q == dsa_pkg::HS_IDLE));
    cov_hold_restart: cover property (idle_q ##1 (phase_q == dsa_pkg::PH_INT));
    cov_latch_stored: cover property (stored);
endmodule // dsa_seq

// ### dsa_uart_model.sv
// uart transmitter buffer model on the far side of the handshake port
module dsa_uart_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_load_n,
    input  wire logic [7:0] i_byte,
    output logic            o_send,
    output logic [7:0]      o_got [2],
    output int              o_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b1;
    int   busy   = 0;
    initial o_count = 0;
    // byte taken at load rising edge, buffer then drains slowly
    always @(posedge i_clk_sys) begin
        last_q <= i_load_n;
        busy   <= (busy > 0) ? busy - 1 : 0;
        if (i_load_n && !last_q && busy == 0) begin  // a load into a full buffer is lost
            o_got[o_count[0]] <= i_byte;
            o_count           <= o_count + 1;
            busy              <= 6;
        end
    end
    assign o_send = (busy == 0);
endmodule // dsa_uart_model

// ### tb_dsa_seq.sv
// bench for the converter sequencer: conversion, byte port, handshake
module tb_dsa_seq;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, cmp = 1, ce_n = 1, lb_n = 1, ub_n = 1, mode = 0, run = 1;
    logic        psel = 0, pen = 0, pwr = 0, err, ce_o_n, ce_oe, lb_o_n, lb_oe, ub_o_n, ub_oe;
    logic        dl_oe, dh_oe, st, az, it, de, zi, sg, prdy, perr, send;
    logic [11:0] addr = 0;
    logic [31:0] wd = 0, rd, res, prd;
    logic [7:0]  dl, got [2];
    logic [5:0]  dh;
    int          failures = 0, check_count = 0, n, cnt;
    always #10 clk = ~clk;
    // pin levels: the design wins while its enable is low
    wire ce_w = ce_oe ? ce_n : ce_o_n;
    wire lb_w = lb_oe ? lb_n : lb_o_n;
    wire ub_w = ub_oe ? ub_n : ub_o_n;
    wire [7:0] bus = ub_w ? dl : {2'b00, dh};
    dsa_seq #(.DIV(1)) i_dut (.i_clk_sys(clk), .i_resetn(rst_n), .i_comparator(cmp),
        .i_mode(mode), .i_run_hold(run), .i_send(send), .i_chip_enable_n(ce_w),
        .o_chip_enable_n(ce_o_n), .o_chip_enable_oe_n(ce_oe), .i_lower_byte_select_n(lb_w),
        .o_lower_byte_select_n(lb_o_n), .o_lower_byte_select_oe_n(lb_oe),
        .i_upper_byte_select_n(ub_w), .o_upper_byte_select_n(ub_o_n),
        .o_upper_byte_select_oe_n(ub_oe), .o_data_low(dl), .o_data_low_oe_n(dl_oe),
        .o_data_high(dh), .o_data_high_oe_n(dh_oe), .o_status(st), .o_auto_zero_phase(az),
        .o_integrate_phase(it), .o_reference_deintegrate_phase(de),
        .o_zero_integrator_phase(zi), .o_sign_bit(sg), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(perr));
    dsa_uart_model i_uart (.i_clk_sys(clk), .i_load_n(ce_oe | ce_o_n), .i_byte(bus),
        .o_send(send), .o_got(got), .o_count(cnt));
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pwr, addr, wd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        err = perr;
        {psel, pen} <= 2'b00;
    endtask
    // counts, verdict, end of run
    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        apb(0, 12'h008, 0);
        chk({rd[5:4], rd[0]}, 0);
        apb(0, 12'h00C, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        while (it !== 1'b1) @(negedge clk);
        chk(st, 1);
        for (n = 0; it === 1'b1; n++) @(negedge clk);
        chk(n, 2048);
        chk(sg, 1);
        repeat (100) @(posedge clk);
        cmp <= 0;
        while (st !== 1'b0) @(negedge clk);
        apb(0, 12'h004, 0);
        res = rd;
        chk(res[11:0] > 99 && res[11:0] < 107, 1);
        chk(res[13:12], 1);
        {cmp, lb_n, ce_n} <= 3'b100;
        repeat (8) @(negedge clk);
        chk({dl_oe, dh_oe, dl}, {2'b01, res[7:0]});
        @(posedge clk) {lb_n, ub_n} <= 2'b10;
        repeat (8) @(negedge clk);
        chk({dl_oe, dh_oe, dh}, {2'b10, res[13:8]});
        @(posedge clk) {ce_n, ub_n} <= 2'b11;
        apb(1, 12'h000, 32'h2);
        while (cnt < 2) @(negedge clk);
        chk(got[0], {2'b00, res[13:8]});
        chk(got[1], res[7:0]);
        repeat (20) @(negedge clk);
        chk(ce_oe, 1);
        while (zi !== 1'b1) @(negedge clk);
        for (n = 0; zi === 1'b1; n++) @(negedge clk);
        chk(n > 0 && n < 1025, 1);
        apb(0, 12'h004, 0);
        chk(rd[13:0], 14'h3FFF);
        // hold past the free-running start point, then restart
        @(posedge clk) run <= 0;
        repeat (1100) @(posedge clk);
        apb(0, 12'h008, 0);
        chk({it, az, rd[1]}, 3'b011);
        run <= 1;
        for (n = 0; st !== 1'b1; n++) @(negedge clk);
        chk(n, 12);
        // mode held high: transfer on the rise and after the next result
        @(posedge clk) mode <= 1;
        while (cnt < 4) @(negedge clk);
        repeat (20) @(negedge clk);
        chk(ce_oe, 0);
        while (it === 1'b1) @(negedge clk);
        @(posedge clk) cmp <= 0;
        while (st !== 1'b0) @(negedge clk);
        @(posedge clk) run <= 0;
        repeat (8) @(negedge clk);
        chk({az, de}, 2'b10);
        while (cnt < 6) @(negedge clk);
        apb(0, 12'h004, 0);
        chk(rd[13:0], 14'h1005);
        chk(got[0], {2'b00, rd[13:8]});
        chk(got[1], rd[7:0]);
        give_verdict;
    end
endmodule // tb_dsa_seq
